// file: verilog/rsc_pkg.sv
// Summary of operation
// - The program runs only with power present and no designated stop or reset input active, and starts only with the start relay set.
// - A host start command sets the start relay and a host stop command clears it.
// - While a stop input is designated, changing the start relay never stops the program and starts it only from the idle state after power-up.
// - The start relay is retained across power loss and restored at power-up while the backup store is valid.
// - If the backup failed, the start relay is cleared at power-up, as reset clears the backup-error selection before it is read.
// - Applying power starts operation and removing it stops operation when the other conditions allow.
// - Any input terminal can be chosen by configuration as the stop input or as the reset input.
// - Releasing stop or reset while the start relay is clear leaves the device stopped.
// - Stop and reset inputs never change the start relay.
// - Stop or reset asserted while running halts the program and turns every output off.
// - When stop and reset are both active, reset behaviour wins.
// - When stopped, outputs are forced off and all data devices keep their values.
// - While reset is active, outputs are off, relays, counters, registers and timers clear, special devices stay.
// - On restart after a stop, clearable devices clear, timers reload their presets, outputs and kept devices stay.
package rsc_pkg;

  // Register offsets (byte addresses)
  localparam logic [3:0] RSC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] RSC_ADDR_CONFIG = 4'h4;
  localparam logic [3:0] RSC_ADDR_STATUS = 4'h8;

  // Control register bits
  localparam int RSC_CTRL_START_BIT = 0;
  localparam int RSC_CTRL_STOP_BIT  = 1;

  // Config register fields
  localparam int RSC_CFG_STOP_EN_BIT  = 0;
  localparam int RSC_CFG_RESET_EN_BIT = 1;
  localparam int RSC_CFG_BKERR_BIT    = 2;
  localparam int RSC_CFG_STOP_SEL_LSB = 8;
  localparam int RSC_CFG_RST_SEL_LSB  = 16;
  localparam int RSC_SEL_W            = 5;

  // Status register bits
  localparam int RSC_ST_RUN_BIT     = 0;
  localparam int RSC_ST_RELAY_BIT   = 1;
  localparam int RSC_ST_RESET_BIT   = 2;
  localparam int RSC_ST_STOP_BIT    = 3;
  localparam int RSC_ST_POWER_BIT   = 4;

  localparam logic [31:0] RSC_ZERO32 = 32'h0000_0000;

  // Run state
  typedef enum logic [1:0] {
    RSC_ST_IDLE    = 2'b00,
    RSC_ST_RUNNING = 2'b01,
    RSC_ST_STOPPED = 2'b10,
    RSC_ST_RESET   = 2'b11
  } rsc_mode_e;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rsc_wb_req_s;

  // Device control strobes towards the program engine
  typedef struct packed {
    logic run;
    logic outputs_off;
    logic clear_all;
    logic clear_clearable;
    logic timer_preset;
  } rsc_ctl_s;

endpackage : rsc_pkg

// file: verilog/rsc_run_stop_control.sv
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
module rsc_run_stop_control #(
  parameter int N_INPUTS = 32                           // Number of input terminals
) (
  input  wire logic                  clk_i,             // Scan clock, 40 MHz
  input  wire logic                  rst_i,             // Power-up reset, sync high
  input  wire rsc_pkg::rsc_wb_req_s  wb_req_i,          // Wishbone request
  output logic [31:0]                wb_dat_o,          // Wishbone read data
  output logic                       wb_ack_o,          // Wishbone ack
  input  wire logic                  power_ok_i,        // Supply present (async)
  input  wire logic [N_INPUTS-1:0]   field_in_i,        // Input terminals (async)
  input  wire logic                  scan_tick_i,       // Scan boundary pulse
  input  wire logic                  retained_relay_i,  // Relay value in backup store
  input  wire logic                  backup_ok_i,       // Backup store valid
  output logic                       relay_store_o,     // Relay value to backup store
  output rsc_pkg::rsc_ctl_s          ctl_o              // Program engine control
);
  import rsc_pkg::*;

  typedef struct packed {
    logic [1:0]          pwr_sync;
    logic [N_INPUTS-1:0] in_s1;
    logic [N_INPUTS-1:0] in_s2;
    logic                relay;
    logic                loaded;
    logic                cfg_stop_en;
    logic                cfg_reset_en;
    logic                cfg_bkerr_run;
    logic [RSC_SEL_W-1:0] stop_sel;
    logic [RSC_SEL_W-1:0] rst_sel;
    rsc_mode_e           mode;
    logic                run_eff;
    logic                halt_prev;
    rsc_ctl_s            ctl;
    logic                ack;
    logic [31:0]         rdat;
  } rsc_state_s;

  rsc_state_s st_reg;
  rsc_state_s st_next;

  logic power_s;
  logic stop_act;
  logic reset_act;
  logic run_cond;
  logic wb_hit;

  // Synchronised levels and selected terminals
  assign power_s   = st_reg.pwr_sync[1];
  assign stop_act  = st_reg.cfg_stop_en  & st_reg.in_s2[st_reg.stop_sel];
  assign reset_act = st_reg.cfg_reset_en & st_reg.in_s2[st_reg.rst_sel];
  assign run_cond  = power_s & st_reg.relay & ~stop_act & ~reset_act;
  assign wb_hit    = wb_req_i.cyc & wb_req_i.stb & ~st_reg.ack;

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.pwr_sync = {st_reg.pwr_sync[0], power_ok_i};
    st_next.in_s1    = field_in_i;
    st_next.in_s2    = st_reg.in_s1;
    st_next.ack      = wb_hit;
    st_next.ctl.clear_clearable = 1'b0;
    st_next.ctl.timer_preset    = 1'b0;

    // Relay load after power-up from store or backup-error selection
    if (!st_reg.loaded) begin
      st_next.loaded = 1'b1;
      st_next.relay  = backup_ok_i ? retained_relay_i : st_reg.cfg_bkerr_run;
    end

    // Register access; only host commands touch the relay
    if (wb_hit && wb_req_i.we) begin
      case (wb_req_i.adr)
        RSC_ADDR_CTRL: begin
          if (wb_req_i.sel[0]) begin
            if (wb_req_i.dat[RSC_CTRL_STOP_BIT]) begin
              st_next.relay = 1'b0;
            end else if (wb_req_i.dat[RSC_CTRL_START_BIT]) begin
              st_next.relay = 1'b1;
            end
          end
        end
        RSC_ADDR_CONFIG: begin
          if (wb_req_i.sel[0]) begin
            st_next.cfg_stop_en   = wb_req_i.dat[RSC_CFG_STOP_EN_BIT];
            st_next.cfg_reset_en  = wb_req_i.dat[RSC_CFG_RESET_EN_BIT];
            st_next.cfg_bkerr_run = wb_req_i.dat[RSC_CFG_BKERR_BIT];
          end
          if (wb_req_i.sel[1]) begin
            st_next.stop_sel = wb_req_i.dat[RSC_CFG_STOP_SEL_LSB +: RSC_SEL_W];
          end
          if (wb_req_i.sel[2]) begin
            st_next.rst_sel = wb_req_i.dat[RSC_CFG_RST_SEL_LSB +: RSC_SEL_W];
          end
        end
        default: begin
        end
      endcase
    end

    // Read data
    st_next.rdat = RSC_ZERO32;
    if (wb_hit && !wb_req_i.we) begin
      case (wb_req_i.adr)
        RSC_ADDR_CTRL: begin
          st_next.rdat[RSC_CTRL_START_BIT] = st_reg.relay;
        end
        RSC_ADDR_CONFIG: begin
          st_next.rdat[RSC_CFG_STOP_EN_BIT]  = st_reg.cfg_stop_en;
          st_next.rdat[RSC_CFG_RESET_EN_BIT] = st_reg.cfg_reset_en;
          st_next.rdat[RSC_CFG_BKERR_BIT]    = st_reg.cfg_bkerr_run;
          st_next.rdat[RSC_CFG_STOP_SEL_LSB +: RSC_SEL_W] = st_reg.stop_sel;
          st_next.rdat[RSC_CFG_RST_SEL_LSB +: RSC_SEL_W]  = st_reg.rst_sel;
        end
        RSC_ADDR_STATUS: begin
          st_next.rdat[RSC_ST_RUN_BIT]   = st_reg.ctl.run;
          st_next.rdat[RSC_ST_RELAY_BIT] = st_reg.relay;
          st_next.rdat[RSC_ST_RESET_BIT] = reset_act;
          st_next.rdat[RSC_ST_STOP_BIT]  = stop_act;
          st_next.rdat[RSC_ST_POWER_BIT] = power_s;
        end
        default: begin
          st_next.rdat = RSC_ZERO32;
        end
      endcase
    end

    // Scan-boundary evaluation of the run state
    if (scan_tick_i && st_reg.loaded) begin
      // Remember whether power, stop or reset held the program back at this scan
      st_next.halt_prev = ~power_s | stop_act | reset_act;
      // Relay changes count only when no stop input is designated or the block is still idle
      if (!st_reg.cfg_stop_en) begin
        st_next.run_eff = run_cond;
      end else begin
        // A running program ignores relay clears; a stopped one restarts only when a halt cause goes away
        if (st_reg.run_eff) begin
          st_next.run_eff = power_s & ~stop_act & ~reset_act;
        end else if (st_reg.mode == RSC_ST_IDLE) begin
          st_next.run_eff = run_cond;
        end else begin
          st_next.run_eff = run_cond & st_reg.halt_prev;
        end
      end
      if (reset_act) begin
        st_next.mode = RSC_ST_RESET;
      end else if (st_next.run_eff) begin
        st_next.mode = RSC_ST_RUNNING;
        if (st_reg.mode == RSC_ST_STOPPED || st_reg.mode == RSC_ST_IDLE) begin
          st_next.ctl.clear_clearable = 1'b1;
          st_next.ctl.timer_preset    = 1'b1;
        end
      end else begin
        case (st_reg.mode)
          RSC_ST_IDLE:    st_next.mode = RSC_ST_IDLE;
          RSC_ST_RUNNING: st_next.mode = RSC_ST_STOPPED;
          RSC_ST_RESET:   st_next.mode = RSC_ST_STOPPED;
          RSC_ST_STOPPED: st_next.mode = RSC_ST_STOPPED;
          default:        st_next.mode = RSC_ST_STOPPED;
        endcase
      end
      st_next.ctl.run         = (st_next.mode == RSC_ST_RUNNING);
      st_next.ctl.outputs_off = (st_next.mode != RSC_ST_RUNNING);
      st_next.ctl.clear_all   = (st_next.mode == RSC_ST_RESET);
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.mode <= RSC_ST_IDLE;
      st_reg.ctl.outputs_off <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs from flip-flops; ack is the registered strobe
  assign wb_dat_o      = st_reg.rdat;
  assign wb_ack_o      = st_reg.ack;
  assign relay_store_o = st_reg.relay;
  assign ctl_o         = st_reg.ctl;

endmodule : rsc_run_stop_control

// file: tb/rsc_run_stop_control_props.sv
`timescale 1ns/1ps
module rsc_run_stop_control_props #(
  parameter int N_INPUTS = 32                      // Input terminal count
) (
  input wire logic                 clk_i,            // Scan clock
  input wire logic                 rst_i,            // Sync reset
  input wire rsc_pkg::rsc_wb_req_s wb_req_i,         // Bus request
  input wire logic [31:0]          wb_dat_o,         // Read data
  input wire logic                 wb_ack_o,         // Bus ack
  input wire logic                 power_ok_i,       // Supply present
  input wire logic [N_INPUTS-1:0]  field_in_i,       // Input terminals
  input wire logic                 scan_tick_i,      // Scan boundary
  input wire logic                 retained_relay_i, // Stored relay
  input wire logic                 backup_ok_i,      // Backup valid
  input wire logic                 relay_store_o,    // Relay to store
  input wire rsc_pkg::rsc_ctl_s    ctl_o             // Engine control
);
  import rsc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer timing and run-state relations
  chk_ack_delay: assert property ($rose(wb_req_i.stb) && wb_req_i.cyc |=> wb_ack_o) else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_off_stopped: assert property (!ctl_o.run |-> ctl_o.outputs_off)
    else $error("outputs on while stopped");
  chk_reset_halts: assert property (ctl_o.clear_all |-> !ctl_o.run && ctl_o.outputs_off)
    else $error("reset without halt");
  chk_restart_pulses: assert property ($rose(ctl_o.run) && !$past(ctl_o.clear_all) |-> ctl_o.clear_clearable && ctl_o.timer_preset)
    else $error("no restart pulses");
  chk_pulse_short: assert property (ctl_o.timer_preset |=> !ctl_o.timer_preset)
    else $error("preset pulse too long");
  chk_scan_edge: assert property ($changed(ctl_o.run) |-> $past(scan_tick_i))
    else $error("run changed off scan");
  chk_relay_steady: assert property (!wb_req_i.stb && !$past(rst_i) |=> $stable(relay_store_o))
    else $error("relay moved without host");
  chk_relay_keep: assert property ($fell(rst_i) && backup_ok_i |=> relay_store_o == $past(retained_relay_i))
    else $error("relay not restored");
  chk_relay_fallback: assert property ($fell(rst_i) && !backup_ok_i |=> !relay_store_o)
    else $error("relay fallback wrong");
  cover property ($rose(ctl_o.run));
  cover property (ctl_o.clear_all);
  cover property ($fell(relay_store_o));
endmodule : rsc_run_stop_control_props
bind rsc_run_stop_control rsc_run_stop_control_props #(.N_INPUTS(N_INPUTS)) i_rsc_run_stop_control_props (
  .clk_i, .rst_i, .wb_req_i, .wb_dat_o, .wb_ack_o, .power_ok_i, .field_in_i,
  .scan_tick_i, .retained_relay_i, .backup_ok_i, .relay_store_o, .ctl_o);

// file: tb/rsc_host_model.sv
`timescale 1ns/1ps
module rsc_host_model (
  input  wire logic           clk_i,      // Scan clock
  input  wire logic           ack_i,      // Bus ack
  input  wire logic [31:0]    dat_i,      // Read data
  input  wire logic           relay_i,    // Relay from block
  input  wire logic           power_i,    // Supply present
  output rsc_pkg::rsc_wb_req_s req_o,     // Bus request
  output logic                tick_o,     // Scan boundary pulse
  output logic                retained_o, // Backup store content
  output logic                tout_o      // Bus answer came late
);
  import rsc_pkg::*;
  logic [2:0] cnt;
  initial begin
    req_o = '0;
    tick_o = 1'b0;
    cnt = 3'h0;
    retained_o = 1'b1;
    tout_o = 1'b0;
  end
  // Scan boundary every eight clocks
  always @(posedge clk_i) begin
    cnt <= cnt + 3'h1;
    tick_o <= (cnt == 3'h7);
  end
  // Backup store tracks the relay while powered
  always @(posedge clk_i) if (power_i) retained_o <= relay_i;
  // Host start/stop and register access, one classic cycle
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    req_o <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1);
    q = dat_i;
    if (n != 2) tout_o <= 1'b1;
    req_o <= '0;
    @(posedge clk_i);
  endtask : xfer
endmodule : rsc_host_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import rsc_pkg::*;
  logic        clk, rst, pwr, bk, tick, ret, ack, rly, tout;
  logic [31:0] fin, dat, q;
  rsc_wb_req_s req;
  rsc_ctl_s    ctl;
  int          error_cnt = 0;
  int          checks = 0;
  rsc_run_stop_control i_rsc_run_stop_control (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .power_ok_i(pwr), .field_in_i(fin), .scan_tick_i(tick), .retained_relay_i(ret),
    .backup_ok_i(bk), .relay_store_o(rly), .ctl_o(ctl));
  rsc_host_model i_rsc_host_model (.clk_i(clk), .ack_i(ack), .dat_i(dat), .relay_i(rly), .power_i(pwr),
    .req_o(req), .tick_o(tick), .retained_o(ret), .tout_o(tout));
  // Clock generation
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_rsc_host_model.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    i_rsc_host_model.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic summarize;
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    wt(3000);
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    pwr = 1'b0;
    bk = 1'b0;
    fin = '0;
    wt(6);
    rst <= 1'b0;
    pwr <= 1'b1;
    wt(2);
    rd(RSC_ADDR_CTRL, 32'h0);
    wt(16);
    chk(ctl.run, 1'b0);
    wr(RSC_ADDR_CTRL, 32'h1);
    wt(16);
    rd(RSC_ADDR_STATUS, 32'h13);
    rd(4'hC, 32'h0);
    pwr <= 1'b0;
    wt(16);
    chk(ctl.run, 1'b0);
    pwr <= 1'b1;
    wt(16);
    chk(ctl.run, 1'b1);
    wr(RSC_ADDR_CONFIG, 32'h0007_0303);
    rd(RSC_ADDR_CONFIG, 32'h0007_0303);
    fin[3] <= 1'b1;
    wt(16);
    chk({ctl.run, ctl.outputs_off, rly}, 3'b011);
    fin[7] <= 1'b1;
    wt(16);
    chk(ctl.clear_all, 1'b1);
    rd(RSC_ADDR_STATUS, 32'h1E);
    fin <= '0;
    wt(16);
    chk(ctl.run, 1'b1);
    wr(RSC_ADDR_CTRL, 32'h2);
    wt(16);
    chk(ctl.run, 1'b1);
    fin[3] <= 1'b1;
    wt(16);
    fin[3] <= 1'b0;
    wt(16);
    chk({ctl.run, rly}, 2'b00);
    wr(RSC_ADDR_CTRL, 32'h1);
    wt(16);
    chk(ctl.run, 1'b0);
    wt(2);
    pwr <= 1'b0;
    rst <= 1'b1;
    bk <= 1'b1;
    wt(6);
    rst <= 1'b0;
    pwr <= 1'b1;
    wt(2);
    rd(RSC_ADDR_CTRL, 32'h1);
    chk(tout, 1'b0);
    summarize();
  end
endmodule : tb
